// File: adc_conv_model.sv
// stand-in for the converter core that feeds the control block
// assumes the bench holds req high for one cycle per conversion wanted
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model
(
   input  wire logic       sys_clk,
   input  wire logic       req,
   input  wire logic [9:0] req_value,
   input  wire logic [3:0] req_wait,
   output logic            conv_end,
   output logic [9:0]      conv_result
);
   logic [3:0] wait_reg = 4'h0;
   logic [9:0] value_reg = 10'h000;
   logic       busy_reg = 1'b0;
   initial conv_end = 1'b0;
   initial conv_result = 10'h000;
   // =============================================================
   // result is only valid with conv_end; it toggles otherwise so a late sample shows up
   always @(posedge sys_clk)
   begin
      conv_end <= 1'b0;
      conv_result <= ~conv_result;
      if (busy_reg && wait_reg != 4'h0)
         wait_reg <= wait_reg - 4'h1;
      else if (busy_reg)
      begin
         busy_reg <= 1'b0;
         conv_end <= 1'b1;
         conv_result <= value_reg;
      end
      if (req)
      begin
         busy_reg <= 1'b1;
         wait_reg <= req_wait;
         value_reg <= req_value;
      end
   end
endmodule
`default_nettype wire

// File: adc_limit_channel_control.sv
// converter control: reference, window check, low_power_wake_mode, resolution, limits, channel routing
// assumes an AXI4-Lite master on sys_clk and a converter core that pulses conv_end
`timescale 1ns/1ps
`include "adc_limit_channel_control_map.svh"
`default_nettype none

module adc_limit_channel_control
#(
   parameter int RESULT_W = 10
)
(
   input  wire logic                sys_clk,
   input  wire logic                arst_n,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic [RESULT_W-1:0] conv_result,
   input  wire logic                conv_end,
   output logic [1:0]               pos_ref_select,
   output logic                     neg_ref_select,
   output logic                     limit_check_select,
   output logic                     low_power_wake_mode_enable,
   output logic                     resolution_select,
   output logic [4:0]               mux_code,
   output logic                     route_ext,
   output logic                     route_temp_sensor,
   output logic                     route_internal_ref,
   output logic                     conversion_done_irq,
   output logic                     irq
);

   // =============================================================
   // reset release
   logic rst_meta_n;
   logic rst_n;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // =============================================================
   // registers
   logic [7:0]          mode_reg;
   logic [7:0]          upper_reg;
   logic [7:0]          lower_reg;
   logic [7:0]          chan_reg;
   logic [RESULT_W-1:0] result_reg;
   logic [1:0]          status_reg;
   logic [1:0]          status_next;
   logic [1:0]          mask_reg;
   logic                done_irq_reg;
   logic                irq_reg;
   logic                route_ext_reg;
   logic                route_temp_reg;
   logic                route_vref_reg;
   logic [4:0]          mux_code_reg;

   // =============================================================
   // write channel: address and data are taken in either order
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic [7:0]  waddr_reg;
   logic [31:0] wdata_reg;
   logic        wlane0_reg;

   wire aw_take  = s_axi_awvalid & awready_reg;
   wire w_take   = s_axi_wvalid & wready_reg;
   wire do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;

   wire wr_hit_mode   = waddr_reg == `ADC_OFF_MODE;
   wire wr_hit_upper  = waddr_reg == `ADC_OFF_UPPER;
   wire wr_hit_lower  = waddr_reg == `ADC_OFF_LOWER;
   wire wr_hit_chan   = waddr_reg == `ADC_OFF_CHAN;
   wire wr_hit_status = waddr_reg == `ADC_OFF_STATUS;
   wire wr_hit_mask   = waddr_reg == `ADC_OFF_MASK;
   wire wr_hit_ro     = waddr_reg == `ADC_OFF_RESULT || waddr_reg == `ADC_OFF_ROUTE;
   wire wr_mapped     = wr_hit_mode | wr_hit_upper | wr_hit_lower | wr_hit_chan
                        | wr_hit_status | wr_hit_mask | wr_hit_ro;

   // only lane 0 carries register bits; upper lanes are ignored
   wire wr_en     = do_write & wlane0_reg;
   wire wr_mode   = wr_en & wr_hit_mode;
   wire wr_upper  = wr_en & wr_hit_upper;
   wire wr_lower  = wr_en & wr_hit_lower;
   wire wr_chan   = wr_en & wr_hit_chan;
   wire wr_status = wr_en & wr_hit_status;
   wire wr_mask   = wr_en & wr_hit_mask;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `ADC_RESP_OKAY;
         waddr_reg   <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wlane0_reg  <= 1'b0;
      end
      else
      begin
         if (aw_take)
         begin
            awready_reg <= 1'b0;
            waddr_reg   <= s_axi_awaddr;
         end
         if (w_take)
         begin
            wready_reg <= 1'b0;
            wdata_reg  <= s_axi_wdata;
            wlane0_reg <= s_axi_wstrb[0];
         end
         if (do_write)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
         end
         else if (bvalid_reg & s_axi_bready)
         begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // =============================================================
   // channel code decode
   wire [4:0] chan_code   = chan_reg[4:0];
   wire       chan_iss    = chan_reg[`ADC_CHAN_ISS];
   wire       code_ext_ok = ~chan_iss & (chan_code[4:3] == 2'b00 || chan_code[4:2] == 3'b100);
   wire       code_temp   = chan_iss & (chan_code == 5'h00);
   wire       code_vref   = chan_iss & (chan_code == 5'h01);

   wire [4:0] wr_code     = wdata_reg[4:0];
   wire       wr_iss      = wdata_reg[`ADC_CHAN_ISS];
   wire       wr_code_ok  = wr_iss ? (wr_code[4:1] == 4'h0)
                                   : (wr_code[4:3] == 2'b00 || wr_code[4:2] == 3'b100);
   wire       wr_pos_bad  = wdata_reg[7:6] == adc_limit_channel_control_pkg::POS_REF_BAD;
   // a write with the unused positive reference code keeps the last legal selection
   wire [7:0] mode_wval   = {wr_pos_bad ? mode_reg[7:6] : wdata_reg[7:6], wdata_reg[5:0]}
                            & `ADC_MODE_WMASK;

   // =============================================================
   // window comparison on the upper eight result bits
   wire [7:0] cmp_value = conv_result[RESULT_W-1:RESULT_W-8];
   wire       in_window = (lower_reg <= cmp_value) && (cmp_value <= upper_reg);
   wire       out_window = (cmp_value < lower_reg) || (upper_reg < cmp_value);
   wire       check_out = mode_reg[`ADC_MODE_CHECK];
   wire       window_hit = check_out ? out_window : in_window;
   wire       done_event = conv_end & window_hit;
   wire       prohib_event = (wr_mode & wr_pos_bad) | (wr_chan & ~wr_code_ok);
   wire [1:0] status_clr = wr_status ? wdata_reg[1:0] : 2'b00;
   wire [1:0] status_set = {prohib_event, done_event};

   // set wins over a clear in the same cycle
   assign status_next = (status_reg & ~status_clr) | status_set;

   wire [RESULT_W-1:0] result_keep = resolution_select
                                     ? {conv_result[RESULT_W-1:2], 2'b00}
                                     : conv_result;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_reg   <= `ADC_RST_MODE;
         upper_reg  <= `ADC_RST_UPPER;
         lower_reg  <= `ADC_RST_LOWER;
         chan_reg   <= `ADC_RST_CHAN;
         mask_reg   <= 2'b00;
         status_reg <= 2'b00;
         result_reg <= '0;
      end
      else
      begin
         if (wr_mode)
            mode_reg <= mode_wval;
         if (wr_upper)
            upper_reg <= wdata_reg[7:0];
         if (wr_lower)
            lower_reg <= wdata_reg[7:0];
         if (wr_chan)
            chan_reg <= wdata_reg[7:0] & `ADC_CHAN_WMASK;
         if (wr_mask)
            mask_reg <= wdata_reg[1:0];
         if (conv_end)
            result_reg <= result_keep;
         status_reg <= status_next;
      end
   end

   // =============================================================
   // outputs toward the converter and the interrupt controller
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_irq_reg   <= 1'b0;
         irq_reg        <= 1'b0;
         route_ext_reg  <= 1'b0;
         route_temp_reg <= 1'b0;
         route_vref_reg <= 1'b0;
         mux_code_reg   <= 5'h00;
      end
      else
      begin
         done_irq_reg   <= done_event;
         irq_reg        <= |(status_next & mask_reg);
         route_ext_reg  <= code_ext_ok;
         route_temp_reg <= code_temp;
         route_vref_reg <= code_vref;
         // prohibited codes route nothing rather than an arbitrary input
         mux_code_reg   <= code_ext_ok ? chan_code : 5'h00;
      end
   end

   assign pos_ref_select      = mode_reg[`ADC_MODE_POS_HI:`ADC_MODE_POS_LO];
   assign neg_ref_select      = mode_reg[`ADC_MODE_NEG];
   assign limit_check_select  = mode_reg[`ADC_MODE_CHECK];
   assign low_power_wake_mode_enable       = mode_reg[`ADC_MODE_LOW_POWER_WAKE_MODE];
   assign resolution_select   = mode_reg[`ADC_MODE_RES];
   assign mux_code            = mux_code_reg;
   assign route_ext           = route_ext_reg;
   assign route_temp_sensor   = route_temp_reg;
   assign route_internal_ref  = route_vref_reg;
   assign conversion_done_irq = done_irq_reg;
   assign irq                 = irq_reg;

   // =============================================================
   // read channel: one cycle from address to data
   logic        arready_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   wire ar_take = s_axi_arvalid & arready_reg;
   wire [7:0] ra = s_axi_araddr;
   wire rd_mapped = ra == `ADC_OFF_MODE || ra == `ADC_OFF_UPPER || ra == `ADC_OFF_LOWER
                    || ra == `ADC_OFF_CHAN || ra == `ADC_OFF_RESULT || ra == `ADC_OFF_STATUS
                    || ra == `ADC_OFF_MASK || ra == `ADC_OFF_ROUTE;
   wire [31:0] rd_value =
      ra == `ADC_OFF_MODE   ? {24'h000000, mode_reg} :
      ra == `ADC_OFF_UPPER  ? {24'h000000, upper_reg} :
      ra == `ADC_OFF_LOWER  ? {24'h000000, lower_reg} :
      ra == `ADC_OFF_CHAN   ? {24'h000000, chan_reg} :
      ra == `ADC_OFF_RESULT ? {{(32-RESULT_W){1'b0}}, result_reg} :
      ra == `ADC_OFF_STATUS ? {30'h00000000, status_reg} :
      ra == `ADC_OFF_MASK   ? {30'h00000000, mask_reg} :
      ra == `ADC_OFF_ROUTE  ? {24'h000000, route_vref_reg, route_temp_reg, route_ext_reg,
                               mux_code_reg} :
      32'h0000_0000;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= `ADC_RESP_OKAY;
      end
      else if (ar_take)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_value;
         rresp_reg   <= rd_mapped ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
      end
      else if (rvalid_reg & s_axi_rready)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // =============================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence seq_mode_write;
      wr_mode;
   endsequence

   sequence seq_conv_inside;
      conv_end && !check_out && (lower_reg <= cmp_value) && (cmp_value <= upper_reg);
   endsequence

   sequence seq_conv_outside;
      conv_end && check_out && ((cmp_value < lower_reg) || (upper_reg < cmp_value));
   endsequence

   a_neg_ref_follow: assert property (seq_mode_write |=>
      neg_ref_select == $past(wdata_reg[`ADC_MODE_NEG]))
      else $error("negative reference select did not follow the mode write");

   a_inside_irq: assert property (seq_conv_inside |=> conversion_done_irq)
      else $error("in-window result raised no done interrupt");

   a_outside_irq: assert property (seq_conv_outside |=> conversion_done_irq)
      else $error("out-of-window result raised no done interrupt");

   a_miss_silent: assert property (conv_end && !window_hit |=> !conversion_done_irq)
      else $error("done interrupt raised for a result that missed the window");

   a_low_power_wake_mode_follow: assert property (seq_mode_write |=>
      low_power_wake_mode_enable == $past(wdata_reg[`ADC_MODE_LOW_POWER_WAKE_MODE]))
      else $error("low_power_wake_mode enable did not follow the mode write");

   a_res_trunc: assert property (conv_end && resolution_select |=>
      result_reg[1:0] == 2'b00 && result_reg[RESULT_W-1:2] == $past(conv_result[RESULT_W-1:2]))
      else $error("eight-bit result kept low bits");

   a_upper_write: assert property (wr_upper |=> upper_reg == $past(wdata_reg[7:0]))
      else $error("upper limit did not take the written value");

   a_lower_write: assert property (wr_lower |=> lower_reg == $past(wdata_reg[7:0]))
      else $error("lower limit did not take the written value");

   a_ext_route: assert property (wr_chan && !wr_iss && wr_code_ok |-> ##2
      route_ext && mux_code == $past(wdata_reg[4:0], 2) && !route_temp_sensor)
      else $error("external channel code not routed");

   a_int_route: assert property (wr_chan && wr_iss && wr_code_ok |-> ##2
      !route_ext && route_temp_sensor == $past(wdata_reg[0] == 1'b0, 2)
      && route_internal_ref == $past(wdata_reg[0], 2))
      else $error("internal source code not routed");

   a_pos_ref_legal: assert property (pos_ref_select != 2'b11)
      else $error("unused positive reference code reached the output");

   a_set_wins: assert property (done_event && status_clr[0] |=> status_reg[0])
      else $error("done status lost to a clear in the same cycle");

endmodule

`default_nettype wire

// File: adc_limit_channel_control_map.svh
// register offsets, field positions and reset values of the converter control block
// assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register
`ifndef ADC_LIMIT_CHANNEL_CONTROL_MAP_SVH
`define ADC_LIMIT_CHANNEL_CONTROL_MAP_SVH

// =============================================================
// register offsets
`define ADC_OFF_MODE        8'h00
`define ADC_OFF_UPPER       8'h04
`define ADC_OFF_LOWER       8'h08
`define ADC_OFF_CHAN        8'h0C
`define ADC_OFF_RESULT      8'h10
`define ADC_OFF_STATUS      8'h14
`define ADC_OFF_MASK        8'h18
`define ADC_OFF_ROUTE       8'h1C

// =============================================================
// converter_mode_third fields
`define ADC_MODE_POS_HI     7
`define ADC_MODE_POS_LO     6
`define ADC_MODE_NEG        5
`define ADC_MODE_CHECK      3
`define ADC_MODE_LOW_POWER_WAKE_MODE     2
`define ADC_MODE_RES        0
`define ADC_MODE_WMASK      8'hED

// =============================================================
// input_channel_select fields
`define ADC_CHAN_ISS        7
`define ADC_CHAN_WMASK      8'h9F

// =============================================================
// status and mask bits
`define ADC_STAT_DONE       0
`define ADC_STAT_PROHIB     1

// =============================================================
// reset values
`define ADC_RST_MODE        8'h00
`define ADC_RST_UPPER       8'hFF
`define ADC_RST_LOWER       8'h00
`define ADC_RST_CHAN        8'h06

// =============================================================
// bus responses
`define ADC_RESP_OKAY       2'h0
`define ADC_RESP_SLVERR     2'h2

`endif

// File: adc_limit_channel_control_pkg.sv
// types of the converter control block
// assumes the offsets and fields come from the map header
package adc_limit_channel_control_pkg;

   typedef enum logic [1:0]
   {
      POS_REF_SUPPLY   = 2'b00,
      POS_REF_PIN      = 2'b01,
      POS_REF_INTERNAL = 2'b10,
      POS_REF_BAD      = 2'b11
   } pos_ref_t;

endpackage

// File: tb_adc_limit_channel_control.sv
// self-checking bench of the converter control block
// assumes the register map header and the converter stand-in model
`timescale 1ns/1ps
`include "adc_limit_channel_control_map.svh"
`default_nettype none
module tb_adc_limit_channel_control;
   logic        sys_clk, arst_n, req, conv_end, pend;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, lo, hi;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, req_wait;
   logic [1:0]  s_axi_bresp, s_axi_rresp, pos_ref_select;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [9:0]  conv_result, req_value;
   logic        neg_ref_select, limit_check_select, low_power_wake_mode_enable, resolution_select, chk;
   logic [4:0]  mux_code;
   logic        route_ext, route_temp_sensor, route_internal_ref, conversion_done_irq, irq;
   int          miscompares = 0;
   int          checked = 0;
   logic [33:0] rd_q[$];
   logic [33:0] rd_note;
   logic [1:0]  b_q[$];
   logic        hit_q[$];
   logic [7:0]  modes[5] = '{8'hAD, 8'h44, 8'hC0, 8'h5F, 8'h00};
   logic [7:0]  reads[5] = '{8'hAD, 8'h44, 8'h40, 8'h4D, 8'h00};
   logic [7:0]  chans[16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                              8'h10, 8'h11, 8'h12, 8'h13, 8'h80, 8'h81, 8'h88, 8'h14};
   logic [7:0]  bounds[6] = '{8'h3F, 8'h40, 8'h41, 8'h7F, 8'h80, 8'h81};

   adc_limit_channel_control uut
   (
      .sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .conv_result, .conv_end, .pos_ref_select, .neg_ref_select,
      .limit_check_select, .low_power_wake_mode_enable, .resolution_select, .mux_code, .route_ext,
      .route_temp_sensor, .route_internal_ref, .conversion_done_irq, .irq
   );
   adc_conv_model partner
   (
      .sys_clk, .req, .req_value, .req_wait, .conv_end, .conv_result
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // =============================================================
   // checking and bus tasks
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic close_out();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic step(inout int n);
      @(posedge sys_clk);
      n++;
      if (n > 60)
      begin
         miscompares++;
         $display("Error handshake expected answer seen timeout");
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      b_q.push_back(er);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         step(n);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      rd_q.push_back({er, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         step(n);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   function automatic logic hit(input logic [9:0] r);
      if (chk)
         return r[9:2] < lo || r[9:2] > hi;
      return r[9:2] >= lo && r[9:2] <= hi;
   endfunction
   function automatic logic [7:0] route(input logic [7:0] c);
      if (c[7:5] == 3'b000 && (c[4:3] == 2'b00 || c[4:2] == 3'b100))
         return {3'b001, c[4:0]};
      if (c == 8'h80)
         return 8'h40;
      if (c == 8'h81)
         return 8'h80;
      return 8'h00;
   endfunction
   task automatic conv(input logic [9:0] r, input logic [3:0] w);
      hit_q.push_back(hit(r));
      req_value <= r;
      req_wait <= w;
      req <= 1'b1;
      @(posedge sys_clk);
   endtask
   // =============================================================
   // watchers: each answer takes the oldest note off its queue
   always @(posedge sys_clk)
   begin
      pend <= conv_end;
      if (pend)
         cmp("done pulse", {31'h0, hit_q.pop_front()}, {31'h0, conversion_done_irq});
      if (s_axi_bvalid && s_axi_bready)
         cmp("bresp", {30'h0, b_q.pop_front()}, {30'h0, s_axi_bresp});
      if (s_axi_rvalid && s_axi_rready)
      begin
         rd_note = rd_q.pop_front();
         cmp("rresp", {30'h0, rd_note[33:32]}, {30'h0, s_axi_rresp});
         cmp("read", rd_note[31:0], s_axi_rdata);
      end
   end
   // =============================================================
   // main sequence
   initial
   begin
      void'($urandom(43));
      {arst_n, req, pend, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      // response readies stay high: every answer is taken on the edge it is offered
      {s_axi_bready, s_axi_rready} = 2'b11;
      {req_value, req_wait, lo, hi, chk} = '0;
      s_axi_wstrb = 4'hF;
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(`ADC_OFF_MODE, `ADC_RST_MODE, `ADC_RESP_OKAY);
      rd(`ADC_OFF_UPPER, `ADC_RST_UPPER, `ADC_RESP_OKAY);
      rd(`ADC_OFF_LOWER, `ADC_RST_LOWER, `ADC_RESP_OKAY);
      rd(`ADC_OFF_CHAN, `ADC_RST_CHAN, `ADC_RESP_OKAY);
      rd(8'h20, 32'h0, `ADC_RESP_SLVERR);
      wr(8'h20, 8'h5A, `ADC_RESP_SLVERR);
      $display("test reset and map done");
      // code 11 and reserved bits are written on purpose; the block must drop them
      foreach (modes[i])
      begin
         wr(`ADC_OFF_MODE, modes[i], `ADC_RESP_OKAY);
         rd(`ADC_OFF_MODE, reads[i], `ADC_RESP_OKAY);
         settle();
         cmp("mode outputs", reads[i] & 8'hED, {pos_ref_select, neg_ref_select, 1'b0,
             limit_check_select, low_power_wake_mode_enable, 1'b0, resolution_select});
      end
      $display("test mode bits done");
      foreach (chans[i])
      begin
         wr(`ADC_OFF_CHAN, chans[i], `ADC_RESP_OKAY);
         rd(`ADC_OFF_CHAN, chans[i] & 8'h9F, `ADC_RESP_OKAY);
         settle();
         cmp("route outputs", route(chans[i]), {route_internal_ref, route_temp_sensor,
             route_ext, mux_code});
         rd(`ADC_OFF_ROUTE, route(chans[i]), `ADC_RESP_OKAY);
      end
      $display("test channel routing done");
      wr(`ADC_OFF_STATUS, 8'h03, `ADC_RESP_OKAY);
      wr(`ADC_OFF_MASK, 8'h01, `ADC_RESP_OKAY);
      lo = 8'h40;
      hi = 8'h80;
      wr(`ADC_OFF_LOWER, lo, `ADC_RESP_OKAY);
      wr(`ADC_OFF_UPPER, hi, `ADC_RESP_OKAY);
      for (int c = 0; c < 2; c++)
      begin
         chk = c[0];
         wr(`ADC_OFF_MODE, chk ? 8'h09 : 8'h00, `ADC_RESP_OKAY);
         foreach (bounds[i])
            conv({bounds[i], 2'b11}, 4'h0);
         for (int k = 0; k < 8; k++)
         begin
            conv(10'($urandom_range(0, 1023)), 4'($urandom_range(0, 6)));
            req <= 1'b0;
            repeat (9) @(posedge sys_clk);
         end
         rd(`ADC_OFF_RESULT, {22'h0, req_value[9:2], chk ? 2'b00 : req_value[1:0]},
            `ADC_RESP_OKAY);
      end
      // a write without lane 0 is answered but must leave the limit alone
      s_axi_wstrb <= 4'hE;
      wr(`ADC_OFF_UPPER, 8'h11, `ADC_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(`ADC_OFF_UPPER, {24'h0, hi}, `ADC_RESP_OKAY);
      $display("test window compare done");
      settle();
      cmp("irq set", 32'h1, {31'h0, irq});
      rd(`ADC_OFF_STATUS, 32'h1, `ADC_RESP_OKAY);
      wr(`ADC_OFF_MASK, 8'h00, `ADC_RESP_OKAY);
      settle();
      cmp("irq masked", 32'h0, {31'h0, irq});
      wr(`ADC_OFF_MASK, 8'h01, `ADC_RESP_OKAY);
      settle();
      cmp("irq unmasked", 32'h1, {31'h0, irq});
      // a window hit lands on the same edge as the status clear; the set must win
      fork
         begin
            conv(10'h3FF, 4'h0);
            req <= 1'b0;
         end
         begin
            @(posedge sys_clk);
            wr(`ADC_OFF_STATUS, 8'h01, `ADC_RESP_OKAY);
         end
      join
      rd(`ADC_OFF_STATUS, 32'h1, `ADC_RESP_OKAY);
      wr(`ADC_OFF_STATUS, 8'h01, `ADC_RESP_OKAY);
      settle();
      cmp("irq cleared", 32'h0, {31'h0, irq});
      rd(`ADC_OFF_STATUS, 32'h0, `ADC_RESP_OKAY);
      $display("test interrupt done");
      close_out();
   end
endmodule
`default_nettype wire
